// [port_pin_config_logic.sv]
// Top level: register file on AXI4-Lite and pin logic for ports L, G, D and the CAN drivers.
`timescale 1ns/1ns
module port_pin_config_logic (
  // Clock, reset and enable
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CE_I,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // Port L pins
  input  wire logic [6:0]  PORT_L_I,
  output logic      [6:0]  PORT_L_O,
  output logic      [6:0]  PORT_L_OE_N_O,
  output logic      [6:0]  PORT_L_PULLUP_O,
  // Port G pins
  input  wire logic [6:0]  PORT_G_I,
  output logic      [5:0]  PORT_G_O,
  output logic      [5:0]  PORT_G_OE_N_O,
  output logic      [5:0]  PORT_G_PULLUP_O,
  output logic             OSC_CLOCK_OUT_O,
  // Port D pins
  output logic      [3:0]  PORT_D_O,
  // CAN transmit pins
  input  wire logic        CAN_TX_A_I,
  input  wire logic        CAN_TX_B_I,
  output logic             CAN_DRIVE_OUT_A_O,
  output logic             CAN_DRIVE_OUT_A_OE_N_O,
  output logic             CAN_DRIVE_OUT_B_O,
  output logic             CAN_DRIVE_OUT_B_OE_N_O,
  // Oscillator clock source for the dedicated output
  input  wire logic        OSC_CLK_I,
  // Power mode requests and serial phase
  output logic             HALT_REQ_O,
  output logic             IDLE_REQ_O,
  output logic             ALT_SK_PHASE_O,
  // Alternate function sources from peripherals
  input  wire logic        PULSE_OUT_ZERO_I,
  input  wire logic        PULSE_OUT_ONE_I,
  input  wire logic        COMPARATOR_B_RESULT_I,
  input  wire logic        COMPARATOR_A_RESULT_I,
  input  wire logic        SERIAL_DATA_OUT_I,
  input  wire logic        SERIAL_CLOCK_PIN_I,
  input  wire logic        TIMER_ONE_IO_I,
  // Synchronised alternate function inputs to peripherals
  output logic      [6:0]  MULTI_INPUT_WAKEUP_O,
  output logic             CAPTURE_PIN_INPUT_O,
  output logic             COMPARATOR_B_NEG_INPUT_O,
  output logic             COMPARATOR_B_POS_INPUT_O,
  output logic             COMPARATOR_A_NEG_INPUT_O,
  output logic             COMPARATOR_A_POS_INPUT_O,
  output logic             SERIAL_DATA_IN_O,
  output logic             SERIAL_CLOCK_IN_O,
  output logic             TIMER_ONE_IO_IN_O,
  output logic             TIMER_ONE_CAPTURE_IN_O,
  output logic             EXTERNAL_IRQ_IN_O
);
  port_bits_if #(.W(7)) l_if ();
  port_bits_if #(.W(6)) g_if ();

  logic [7:0]  l_cfg_r;
  logic [7:0]  l_data_r;
  logic [7:0]  g_cfg_r;
  logic [7:0]  g_data_r;
  logic [3:0]  d_data_r;
  logic [1:0]  can_en_r;
  logic [7:0]  alt_sel_r;
  logic [6:0]  l_level;
  logic [6:0]  g_level;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        halt_r;
  logic        idle_r;
  logic        wr_go;
  logic        rd_go;
  logic        wr_lane0;
  logic [31:0] rd_word;
  logic        rd_hit;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == gpio_pkg::OFS_L_CFG) || (a == gpio_pkg::OFS_L_DATA) ||
                (a == gpio_pkg::OFS_L_PIN) || (a == gpio_pkg::OFS_G_CFG) ||
                (a == gpio_pkg::OFS_G_DATA) || (a == gpio_pkg::OFS_G_PIN) ||
                (a == gpio_pkg::OFS_D_DATA) || (a == gpio_pkg::OFS_CAN_CTRL) ||
                (a == gpio_pkg::OFS_ALT_SEL);
  endfunction

  pin_sync #(.W(7)) u_sync_l (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .ce_i    (CE_I),
    .pin_i   (PORT_L_I),
    .level_o (l_level)
  );

  pin_sync #(.W(7)) u_sync_g (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RESET_I),
    .ce_i    (CE_I),
    .pin_i   (PORT_G_I),
    .level_o (g_level)
  );

  port_pad u_pad_l (
    .p (l_if.pad)
  );

  port_pad u_pad_g (
    .p (g_if.pad)
  );

  // Write address and data are taken together in one cycle; no write is pending while a response waits.
  assign wr_go           = CE_I & S_AXI_AWVALID_I & S_AXI_WVALID_I & ~bvalid_r;
  assign rd_go           = CE_I & S_AXI_ARVALID_I & ~rvalid_r;
  assign wr_lane0        = wr_go & S_AXI_WSTRB_I[0];
  assign S_AXI_AWREADY_O = wr_go;
  assign S_AXI_WREADY_O  = wr_go;
  assign S_AXI_ARREADY_O = rd_go;
  assign S_AXI_BVALID_O  = bvalid_r;
  assign S_AXI_BRESP_O   = bresp_r;
  assign S_AXI_RVALID_O  = rvalid_r;
  assign S_AXI_RDATA_O   = rdata_r;
  assign S_AXI_RRESP_O   = rresp_r;

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bvalid_r <= 1'b0;
      bresp_r  <= gpio_pkg::RESP_OKAY;
    end else if (CE_I) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= is_mapped(S_AXI_AWADDR_I) ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Ports L and G reset to Hi-Z inputs; port D resets high.
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      l_cfg_r   <= gpio_pkg::RST_CFG;
      l_data_r  <= gpio_pkg::RST_DATA;
      g_cfg_r   <= gpio_pkg::RST_CFG;
      g_data_r  <= gpio_pkg::RST_DATA;
      d_data_r  <= gpio_pkg::RST_D;
      can_en_r  <= gpio_pkg::RST_CAN;
      alt_sel_r <= gpio_pkg::RST_ALT;
    end else if (wr_lane0) begin
      case (S_AXI_AWADDR_I)
        gpio_pkg::OFS_L_CFG: begin
          l_cfg_r <= S_AXI_WDATA_I[7:0];
        end
        gpio_pkg::OFS_L_DATA: begin
          l_data_r <= S_AXI_WDATA_I[7:0];
        end
        gpio_pkg::OFS_G_CFG: begin
          g_cfg_r <= S_AXI_WDATA_I[7:0];
        end
        gpio_pkg::OFS_G_DATA: begin
          g_data_r <= S_AXI_WDATA_I[7:0];
        end
        gpio_pkg::OFS_D_DATA: begin
          d_data_r <= S_AXI_WDATA_I[3:0];
        end
        gpio_pkg::OFS_CAN_CTRL: begin
          can_en_r <= S_AXI_WDATA_I[1:0];
        end
        gpio_pkg::OFS_ALT_SEL: begin
          alt_sel_r <= S_AXI_WDATA_I[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Halt and idle are requests of one cycle, raised by a write of a one with byte lane 0 strobed.
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      halt_r <= 1'b0;
      idle_r <= 1'b0;
    end else if (CE_I) begin
      halt_r <= wr_lane0 && (S_AXI_AWADDR_I == gpio_pkg::OFS_G_DATA) &&
                S_AXI_WDATA_I[gpio_pkg::BIT_HALT];
      idle_r <= wr_lane0 && (S_AXI_AWADDR_I == gpio_pkg::OFS_G_DATA) &&
                S_AXI_WDATA_I[gpio_pkg::BIT_IDLE];
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR_I)
      gpio_pkg::OFS_L_CFG:    rd_word[7:0] = l_cfg_r;
      gpio_pkg::OFS_L_DATA:   rd_word[7:0] = l_data_r;
      gpio_pkg::OFS_L_PIN:    rd_word[6:0] = l_level;
      gpio_pkg::OFS_G_CFG:    rd_word[7:0] = g_cfg_r;
      gpio_pkg::OFS_G_DATA:   rd_word[5:0] = g_data_r[5:0];
      gpio_pkg::OFS_G_PIN:    rd_word[6:0] = g_level;
      gpio_pkg::OFS_D_DATA:   rd_word[3:0] = d_data_r;
      gpio_pkg::OFS_CAN_CTRL: rd_word[1:0] = can_en_r;
      gpio_pkg::OFS_ALT_SEL:  rd_word[7:0] = alt_sel_r;
      default:                rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= gpio_pkg::RESP_OKAY;
    end else if (CE_I) begin
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= rd_hit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Alternate outputs replace the data bit only; the config bit still decides whether the pin drives.
  always_comb begin
    l_if.cfg    = l_cfg_r[6:0];
    l_if.dat    = l_data_r[6:0];
    l_if.dat[6] = alt_sel_r[gpio_pkg::ALT_PULSE_ZERO]   ? PULSE_OUT_ZERO_I :
                  alt_sel_r[gpio_pkg::ALT_CMP_B_RESULT] ? COMPARATOR_B_RESULT_I : l_data_r[6];
    l_if.dat[5] = alt_sel_r[gpio_pkg::ALT_PULSE_ONE]    ? PULSE_OUT_ONE_I : l_data_r[5];
    l_if.dat[2] = alt_sel_r[gpio_pkg::ALT_CMP_A_RESULT] ? COMPARATOR_A_RESULT_I : l_data_r[2];
    g_if.cfg    = g_cfg_r[5:0];
    g_if.dat    = g_data_r[5:0];
    g_if.dat[5] = alt_sel_r[gpio_pkg::ALT_SER_CLK_OUT]  ? SERIAL_CLOCK_PIN_I : g_data_r[5];
    g_if.dat[4] = alt_sel_r[gpio_pkg::ALT_SER_DATA_OUT] ? SERIAL_DATA_OUT_I : g_data_r[4];
    g_if.dat[3] = alt_sel_r[gpio_pkg::ALT_TIMER_IO]     ? TIMER_ONE_IO_I : g_data_r[3];
  end

  assign PORT_L_O        = l_if.pad_out;
  assign PORT_L_OE_N_O   = l_if.pad_oe_n;
  assign PORT_L_PULLUP_O = l_if.pad_pullup;
  assign PORT_G_O        = g_if.pad_out;
  assign PORT_G_OE_N_O   = g_if.pad_oe_n;
  assign PORT_G_PULLUP_O = g_if.pad_pullup;
  // The clock leaves on its own pin with no register so its waveform is not resampled.
  assign OSC_CLOCK_OUT_O = OSC_CLK_I;
  assign PORT_D_O        = d_data_r;

  assign CAN_DRIVE_OUT_A_O      = CAN_TX_A_I;
  assign CAN_DRIVE_OUT_A_OE_N_O = ~can_en_r[gpio_pkg::CAN_EN_A];
  assign CAN_DRIVE_OUT_B_O      = CAN_TX_B_I;
  assign CAN_DRIVE_OUT_B_OE_N_O = ~can_en_r[gpio_pkg::CAN_EN_B];

  assign HALT_REQ_O     = halt_r;
  assign IDLE_REQ_O     = idle_r;
  assign ALT_SK_PHASE_O = g_cfg_r[gpio_pkg::BIT_ALT_SK];

  assign MULTI_INPUT_WAKEUP_O     = l_level;
  assign CAPTURE_PIN_INPUT_O      = l_level[6];
  assign COMPARATOR_B_NEG_INPUT_O = l_level[5];
  assign COMPARATOR_B_POS_INPUT_O = l_level[4];
  assign COMPARATOR_A_NEG_INPUT_O = l_level[1];
  assign COMPARATOR_A_POS_INPUT_O = l_level[0];
  assign SERIAL_DATA_IN_O         = g_level[6];
  assign SERIAL_CLOCK_IN_O        = g_level[5];
  assign TIMER_ONE_IO_IN_O        = g_level[3];
  assign TIMER_ONE_CAPTURE_IN_O   = g_level[2];
  assign EXTERNAL_IRQ_IN_O        = g_level[0];
endmodule

// [gpio_pkg.sv]
// Register map, reset values and field positions for the port pin logic.
package gpio_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_L_CFG    = 8'h00;
  localparam logic [7:0] OFS_L_DATA   = 8'h04;
  localparam logic [7:0] OFS_L_PIN    = 8'h08;
  localparam logic [7:0] OFS_G_CFG    = 8'h0c;
  localparam logic [7:0] OFS_G_DATA   = 8'h10;
  localparam logic [7:0] OFS_G_PIN    = 8'h14;
  localparam logic [7:0] OFS_D_DATA   = 8'h18;
  localparam logic [7:0] OFS_CAN_CTRL = 8'h1c;
  localparam logic [7:0] OFS_ALT_SEL  = 8'h20;
  localparam logic [7:0] RST_CFG      = 8'h00;
  localparam logic [7:0] RST_DATA     = 8'h00;
  localparam logic [3:0] RST_D        = 4'hf;
  localparam logic [1:0] RST_CAN      = 2'h0;
  localparam logic [7:0] RST_ALT      = 8'h00;
  localparam int L_W              = 7;
  localparam int G_IO_W           = 6;
  localparam int BIT_HALT         = 7;
  localparam int BIT_IDLE         = 6;
  localparam int BIT_ALT_SK       = 6;
  localparam int CAN_EN_A         = 0;
  localparam int CAN_EN_B         = 1;
  localparam int ALT_PULSE_ZERO   = 0;
  localparam int ALT_PULSE_ONE    = 1;
  localparam int ALT_CMP_B_RESULT = 2;
  localparam int ALT_CMP_A_RESULT = 3;
  localparam int ALT_SER_DATA_OUT = 4;
  localparam int ALT_SER_CLK_OUT  = 5;
  localparam int ALT_TIMER_IO     = 6;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [port_bits_if.sv]
// Configuration, data and drive signals of one bidirectional port.
`timescale 1ns/1ns
interface port_bits_if #(parameter int W = 8);
  logic [W-1:0] cfg;
  logic [W-1:0] dat;
  logic [W-1:0] pad_out;
  logic [W-1:0] pad_oe_n;
  logic [W-1:0] pad_pullup;
  modport ctrl (output cfg, output dat, input pad_out, input pad_oe_n, input pad_pullup);
  modport pad  (input cfg, input dat, output pad_out, output pad_oe_n, output pad_pullup);
endinterface

// [pin_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Each bit updates on its own so one bouncing pin does not hold back the others.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= '0;
    end else if (ce_i) begin
      level_o <= (s2_r & s3_r) | (level_o & (s2_r | s3_r));
    end
  end
endmodule

// [port_pad.sv]
// Turns configuration and data bits into pad drive, enable and pull-up controls.
`timescale 1ns/1ns
module port_pad (
  port_bits_if.pad p
);
  always_comb begin
    p.pad_out    = p.dat;
    p.pad_oe_n   = ~p.cfg;
    p.pad_pullup = ~p.cfg & p.dat;
  end
endmodule

// [port_pin_config_logic_props.sv]
// Concurrent checks on the top-level ports of the port pin logic.
`timescale 1ns/1ns
module port_pin_config_logic_props (
  // Clock, reset, bus and port D output
  input wire logic        SYS_CLK_I, RESET_I, CE_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I, S_AXI_WREADY_O, S_AXI_RVALID_O,
  input wire logic [7:0]  S_AXI_AWADDR_I, S_AXI_ARADDR_I,
  input wire logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O,
  input wire logic [3:0]  S_AXI_WSTRB_I, PORT_D_O,
  // Pins and mode outputs
  input wire logic [6:0]  PORT_L_I, PORT_L_OE_N_O, MULTI_INPUT_WAKEUP_O,
  input wire logic        CAN_DRIVE_OUT_A_OE_N_O, CAN_DRIVE_OUT_B_OE_N_O,
  input wire logic        HALT_REQ_O, IDLE_REQ_O, ALT_SK_PHASE_O
);
  logic wr;
  assign wr = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O && S_AXI_WSTRB_I[0];
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  cfg_drive_a:
    assert property (wr && S_AXI_AWADDR_I == gpio_pkg::OFS_L_CFG |=> PORT_L_OE_N_O == ~$past(S_AXI_WDATA_I[6:0]))
    else $error("port L drive enable wrong");
  g_rd_zero_a:
    assert property ($rose(S_AXI_RVALID_O) && $past(S_AXI_ARADDR_I) == gpio_pkg::OFS_G_DATA |-> !S_AXI_RDATA_O[7:6])
    else $error("port G data top bits read nonzero");
  halt_pulse_a:
    assert property (wr && S_AXI_AWADDR_I == gpio_pkg::OFS_G_DATA && S_AXI_WDATA_I[7] |=> HALT_REQ_O ##1 !HALT_REQ_O)
    else $error("halt pulse wrong");
  idle_cause_a:
    assert property (IDLE_REQ_O |-> $past(wr && S_AXI_AWADDR_I == gpio_pkg::OFS_G_DATA && S_AXI_WDATA_I[6]))
    else $error("idle pulse without cause");
  sk_phase_a:
    assert property (wr && S_AXI_AWADDR_I == gpio_pkg::OFS_G_CFG |=> ALT_SK_PHASE_O == $past(S_AXI_WDATA_I[6]))
    else $error("serial phase wrong");
  can_enable_a:
    assert property (wr && S_AXI_AWADDR_I == gpio_pkg::OFS_CAN_CTRL |=>
      {CAN_DRIVE_OUT_B_OE_N_O, CAN_DRIVE_OUT_A_OE_N_O} == ~$past(S_AXI_WDATA_I[1:0]))
    else $error("CAN drive enable wrong");
  reset_state_a:
    assert property ($fell(RESET_I) |-> PORT_D_O == gpio_pkg::RST_D && &PORT_L_OE_N_O)
    else $error("reset state wrong");
  sync_level_a:
    assert property ((CE_I && $stable(PORT_L_I)) [*6] |-> MULTI_INPUT_WAKEUP_O == PORT_L_I)
    else $error("wake-up level does not follow pin");
endmodule
bind port_pin_config_logic port_pin_config_logic_props props_i (.*);

// [board_model.sv]
// Board-side model of the port pins: external drivers, pull-ups and floating lines.
`timescale 1ns/1ns
module board_model #(
  parameter int W = 7
) (
  // Clock
  input  wire logic         clk_i,
  // Pad controls from the device
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] pullup_i,
  // External drivers on the board
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  // Resolved pin levels
  output logic      [W-1:0] pin_o
);
  // An undriven line must not look settled, so it toggles every cycle.
  logic [W-1:0] wander_r = '0;
  always @(posedge clk_i) wander_r <= ~wander_r;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_o[i] = !oe_n_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] : pullup_i[i] ? 1'b1 : wander_r[i];
    end
  end
endmodule

// [port_pin_config_logic_tb.sv]
// Self-checking testbench for the port pin logic.
`timescale 1ns/1ns
module port_pin_config_logic_tb;
  logic SYS_CLK_I, RESET_I, CE_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O;
  logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I;
  logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
  logic [3:0] S_AXI_WSTRB_I, PORT_D_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [6:0] PORT_L_I, PORT_L_O, PORT_L_OE_N_O, PORT_L_PULLUP_O, PORT_G_I, MULTI_INPUT_WAKEUP_O;
  logic [5:0] PORT_G_O, PORT_G_OE_N_O, PORT_G_PULLUP_O;
  logic OSC_CLOCK_OUT_O, CAN_TX_A_I, CAN_TX_B_I, CAN_DRIVE_OUT_A_O, CAN_DRIVE_OUT_A_OE_N_O, CAN_DRIVE_OUT_B_O;
  logic CAN_DRIVE_OUT_B_OE_N_O, OSC_CLK_I, HALT_REQ_O, IDLE_REQ_O, ALT_SK_PHASE_O, PULSE_OUT_ZERO_I;
  logic PULSE_OUT_ONE_I, COMPARATOR_B_RESULT_I, COMPARATOR_A_RESULT_I, SERIAL_DATA_OUT_I, SERIAL_CLOCK_PIN_I;
  logic TIMER_ONE_IO_I, CAPTURE_PIN_INPUT_O, COMPARATOR_B_NEG_INPUT_O, COMPARATOR_B_POS_INPUT_O;
  logic COMPARATOR_A_NEG_INPUT_O, COMPARATOR_A_POS_INPUT_O, SERIAL_DATA_IN_O, SERIAL_CLOCK_IN_O;
  logic TIMER_ONE_IO_IN_O, TIMER_ONE_CAPTURE_IN_O, EXTERNAL_IRQ_IN_O;
  logic [6:0] ext_en_l, ext_v_l, ext_en_g, ext_v_g;
  int error_cnt, checked, halt_cnt, idle_cnt;
  port_pin_config_logic dut (.*);
  board_model #(.W(7)) board_l (.clk_i(SYS_CLK_I), .out_i(PORT_L_O), .oe_n_i(PORT_L_OE_N_O),
    .pullup_i(PORT_L_PULLUP_O), .ext_en_i(ext_en_l), .ext_val_i(ext_v_l), .pin_o(PORT_L_I));
  board_model #(.W(7)) board_g (.clk_i(SYS_CLK_I), .out_i({1'b0, PORT_G_O}), .oe_n_i({1'b1, PORT_G_OE_N_O}),
    .pullup_i({1'b0, PORT_G_PULLUP_O}), .ext_en_i(ext_en_g), .ext_val_i(ext_v_g), .pin_o(PORT_G_I));
  initial begin
    SYS_CLK_I = 1'b0;
    forever #20 SYS_CLK_I = ~SYS_CLK_I;
  end
  always @(posedge SYS_CLK_I) begin
    OSC_CLK_I <= ~OSC_CLK_I;
    halt_cnt <= halt_cnt + 32'(HALT_REQ_O === 1'b1);
    idle_cnt <= idle_cnt + 32'(IDLE_REQ_O === 1'b1);
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge SYS_CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_WSTRB_I <= s;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge SYS_CLK_I);
      ta = ta | (S_AXI_AWREADY_O === 1'b1);
      tw = tw | (S_AXI_WREADY_O === 1'b1);
      @(posedge SYS_CLK_I);
      if (ta) S_AXI_AWVALID_I <= 1'b0;
      if (tw) S_AXI_WVALID_I <= 1'b0;
    end
    do @(negedge SYS_CLK_I); while (S_AXI_BVALID_O !== 1'b1);
    chk("bresp", 32'(S_AXI_BRESP_O), 32'(er));
    @(posedge SYS_CLK_I);
    S_AXI_BREADY_I <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge SYS_CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do @(negedge SYS_CLK_I); while (S_AXI_ARREADY_O !== 1'b1);
    @(posedge SYS_CLK_I);
    S_AXI_ARVALID_I <= 1'b0;
    do @(negedge SYS_CLK_I); while (S_AXI_RVALID_O !== 1'b1);
    chk("rdata", S_AXI_RDATA_O, e);
    chk("rresp", 32'(S_AXI_RRESP_O), 32'(er));
    @(posedge SYS_CLK_I);
    S_AXI_RREADY_I <= 1'b0;
  endtask
  task t_reset;
    chk("port_d", 32'(PORT_D_O), 32'hf);
    chk("l_oe_n", 32'(PORT_L_OE_N_O), 32'h7f);
    chk("g_pull", 32'(PORT_G_PULLUP_O), 32'h0);
    chk("can_oe_n", 32'({CAN_DRIVE_OUT_B_OE_N_O, CAN_DRIVE_OUT_A_OE_N_O}), 32'h3);
    rc(gpio_pkg::OFS_G_CFG, 32'h0, gpio_pkg::RESP_OKAY);
  endtask
  // Each call puts all four config/data pairs on different bits at once.
  task t_modes(input logic [6:0] c, input logic [6:0] d);
    wr(gpio_pkg::OFS_L_CFG, 32'(c), 4'h1, gpio_pkg::RESP_OKAY);
    wr(gpio_pkg::OFS_L_DATA, 32'(d), 4'h1, gpio_pkg::RESP_OKAY);
    chk("l_oe_n", 32'(PORT_L_OE_N_O), 32'(c ^ 7'h7f));
    chk("l_pull", 32'(PORT_L_PULLUP_O), 32'(~c & d));
    chk("l_out", 32'(PORT_L_O & c), 32'(d & c));
    rc(gpio_pkg::OFS_L_CFG, 32'(c), gpio_pkg::RESP_OKAY);
    rc(gpio_pkg::OFS_L_DATA, 32'(d), gpio_pkg::RESP_OKAY);
    repeat (6) @(posedge SYS_CLK_I);
    chk("l_pin", 32'(PORT_L_I & (c | d)), 32'(d));
    chk("wake", 32'(MULTI_INPUT_WAKEUP_O & (c | d)), 32'(d));
  endtask
  task t_gport;
    wr(gpio_pkg::OFS_G_DATA, 32'hff, 4'h1, gpio_pkg::RESP_OKAY);
    rc(gpio_pkg::OFS_G_DATA, 32'h3f, gpio_pkg::RESP_OKAY);
    wr(gpio_pkg::OFS_G_DATA, 32'hc0, 4'h0, gpio_pkg::RESP_OKAY);
    chk("halts", 32'(halt_cnt), 32'h1);
    chk("idles", 32'(idle_cnt), 32'h1);
    wr(gpio_pkg::OFS_G_CFG, 32'h4f, 4'h1, gpio_pkg::RESP_OKAY);
    chk("sk_phase", 32'(ALT_SK_PHASE_O), 32'h1);
    chk("g_oe_n", 32'(PORT_G_OE_N_O), 32'h30);
    chk("osc", 32'(OSC_CLOCK_OUT_O), 32'(OSC_CLK_I));
  endtask
  task t_pins;
    wr(gpio_pkg::OFS_L_CFG, 32'h0, 4'h1, gpio_pkg::RESP_OKAY);
    wr(gpio_pkg::OFS_G_CFG, 32'h0, 4'h1, gpio_pkg::RESP_OKAY);
    ext_en_l <= 7'h7f;
    ext_v_l <= 7'h55;
    ext_en_g <= 7'h7f;
    ext_v_g <= 7'h45;
    repeat (6) @(posedge SYS_CLK_I);
    rc(gpio_pkg::OFS_L_PIN, 32'h55, gpio_pkg::RESP_OKAY);
    rc(gpio_pkg::OFS_G_PIN, 32'h45, gpio_pkg::RESP_OKAY);
    chk("alt_in", 32'({CAPTURE_PIN_INPUT_O, COMPARATOR_B_NEG_INPUT_O, COMPARATOR_A_POS_INPUT_O, SERIAL_DATA_IN_O,
      TIMER_ONE_CAPTURE_IN_O, EXTERNAL_IRQ_IN_O, SERIAL_CLOCK_IN_O}), 32'h5e);
    chk("alt_in2", 32'({COMPARATOR_B_POS_INPUT_O, COMPARATOR_A_NEG_INPUT_O, TIMER_ONE_IO_IN_O}), 32'h4);
    ext_en_l <= 7'h0;
    ext_en_g <= 7'h0;
  endtask
  task t_misc;
    {PULSE_OUT_ZERO_I, PULSE_OUT_ONE_I, COMPARATOR_A_RESULT_I, SERIAL_DATA_OUT_I} <= 4'hf;
    {SERIAL_CLOCK_PIN_I, TIMER_ONE_IO_I, CAN_TX_A_I} <= 3'h7;
    for (int k = 1; k < 4; k++) begin
      wr(gpio_pkg::OFS_CAN_CTRL, 32'(k), 4'h1, gpio_pkg::RESP_OKAY);
      chk("can_oe_n", 32'({CAN_DRIVE_OUT_B_OE_N_O, CAN_DRIVE_OUT_A_OE_N_O}), 32'(~k & 3));
    end
    chk("can_out", 32'({CAN_DRIVE_OUT_B_O, CAN_DRIVE_OUT_A_O}), 32'h1);
    wr(gpio_pkg::OFS_ALT_SEL, 32'h7f, 4'h1, gpio_pkg::RESP_OKAY);
    wr(gpio_pkg::OFS_L_CFG, 32'h64, 4'h1, gpio_pkg::RESP_OKAY);
    wr(gpio_pkg::OFS_G_CFG, 32'h38, 4'h1, gpio_pkg::RESP_OKAY);
    wr(gpio_pkg::OFS_G_DATA, 32'h0, 4'h1, gpio_pkg::RESP_OKAY);
    // Port L data is cleared so that only the alternate sources can drive the checked bits high.
    wr(gpio_pkg::OFS_L_DATA, 32'h0, 4'h1, gpio_pkg::RESP_OKAY);
    chk("l_alt", 32'(PORT_L_O & 7'h64), 32'h64);
    chk("g_alt", 32'(PORT_G_O & 6'h38), 32'h38);
    wr(gpio_pkg::OFS_D_DATA, 32'h5, 4'h1, gpio_pkg::RESP_OKAY);
    chk("port_d", 32'(PORT_D_O), 32'h5);
    wr(8'h40, 32'h1, 4'h1, gpio_pkg::RESP_SLVERR);
    rc(8'h40, 32'h0, gpio_pkg::RESP_SLVERR);
  endtask
  // Pins move while the clock enable is low; levels and a pending read must wait for it.
  task t_freeze;
    @(posedge SYS_CLK_I);
    ext_en_l <= 7'h7f;
    ext_v_l <= 7'h2a;
    repeat (6) @(posedge SYS_CLK_I);
    CE_I <= 1'b0;
    ext_v_l <= 7'h55;
    fork
      rc(gpio_pkg::OFS_L_PIN, 32'h2a, gpio_pkg::RESP_OKAY);
      begin
        repeat (4) @(posedge SYS_CLK_I);
        chk("ce_hold", 32'({S_AXI_ARREADY_O, MULTI_INPUT_WAKEUP_O}), 32'h2a);
        CE_I <= 1'b1;
      end
    join
    repeat (6) @(posedge SYS_CLK_I);
    chk("ce_run", 32'(MULTI_INPUT_WAKEUP_O), 32'h55);
    ext_en_l <= 7'h0;
  endtask
  // A second reset in mid-run must undo what the earlier scenarios wrote.
  task t_rst2;
    wr(gpio_pkg::OFS_G_DATA, 32'h3f, 4'h1, gpio_pkg::RESP_OKAY);
    chk("g_pull", 32'(PORT_G_PULLUP_O), 32'h7);
    RESET_I <= 1'b1;
    repeat (2) @(posedge SYS_CLK_I);
    RESET_I <= 1'b0;
    @(posedge SYS_CLK_I);
    t_reset;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {RESET_I, CE_I, OSC_CLK_I, CAN_TX_A_I, CAN_TX_B_I} = 5'h18;
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} = 5'h0;
    {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I, S_AXI_WSTRB_I} = '0;
    {PULSE_OUT_ZERO_I, PULSE_OUT_ONE_I, COMPARATOR_B_RESULT_I, COMPARATOR_A_RESULT_I} = 4'h0;
    {SERIAL_DATA_OUT_I, SERIAL_CLOCK_PIN_I, TIMER_ONE_IO_I} = 3'h0;
    {ext_en_l, ext_v_l, ext_en_g, ext_v_g} = '0;
    {error_cnt, checked, halt_cnt, idle_cnt} = '0;
    repeat (10) @(posedge SYS_CLK_I);
    RESET_I <= 1'b0;
    @(posedge SYS_CLK_I);
    t_reset;
    t_modes(7'h0c, 7'h0a);
    t_modes(7'h73, 7'h75);
    t_gport;
    t_pins;
    t_freeze;
    t_misc;
    t_rst2;
    print_verdict;
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge SYS_CLK_I);
    error_cnt++;
    print_verdict;
  end
endmodule
